/* File: hw/pfrc_cfg.svh */
// Purpose: constants for the power-fail refresh controller
// Assumes: 200 MHz system clock, 5 ns period
// Notes: times kept in their printed units, cycle counts derived
`ifndef PFRC_CFG_SVH
`define PFRC_CFG_SVH
`define PFRC_CLK_MHZ 200
`define PFRC_PRE_US 3
`define PFRC_PRE_CYC ((`PFRC_PRE_US * `PFRC_CLK_MHZ))
`define PFRC_CE_NS 500
`define PFRC_CE_CYC ((`PFRC_CE_NS * `PFRC_CLK_MHZ) / 1000)
`define PFRC_DIST_NS 62500
`define PFRC_DIST_CYC ((`PFRC_DIST_NS * `PFRC_CLK_MHZ) / 1000)
`define PFRC_ROW_BITS 5
`define PFRC_BANK_ABITS 12
`endif

/* File: hw/pfrc_pkg.sv */
// Purpose: types for the power-fail refresh controller
// Assumes: constants live in pfrc_cfg.svh
// Notes: one refresh sequencer state type
package pfrc_pkg;
  typedef enum logic [1:0] {
    PFRC_IDLE,
    PFRC_PRE,
    PFRC_CE
  } pfrc_ref_e;
endpackage

/* File: hw/pfrc_pulse.sv */
// Purpose: retriggerable-free one-shot of fixed length
// Assumes: trig is a one-cycle pulse
// Notes: trig during a running pulse is ignored
`timescale 1ns/1ps
module pfrc_pulse
#(
  parameter int LEN = 100
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic trig,
  output logic active,
  output logic done
);
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  initial
  begin
    if (LEN < 1)
      $error("pfrc_pulse: LEN must be at least 1");
  end

  always_comb
  begin
    next_cnt = cnt;
    if (cnt != '0)
      next_cnt = cnt - 1'b1;
    else if (trig)
      next_cnt = CW'(LEN);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign active = (cnt != '0);
  assign done = (cnt == CW'(1));
endmodule

/* File: hw/pfrc_top.sv */
// Purpose: refresh and power-fail mode control for a battery-backed dynamic memory
// Assumes: all inputs synchronous to clk; mem_clk and ref_clk are sampled levels
// Notes: memory clock lines modelled as one drive enable per source, never both
`timescale 1ns/1ps
`include "pfrc_cfg.svh"
module pfrc_top
import pfrc_pkg::*;
#(
  parameter int PRE_CYC = `PFRC_PRE_CYC,
  parameter int CE_CYC = `PFRC_CE_CYC,
  parameter int DIST_CYC = `PFRC_DIST_CYC,
  parameter int ROW_BITS = `PFRC_ROW_BITS,
  parameter int BANK_ABITS = `PFRC_BANK_ABITS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // refresh and power fail
  input wire logic ref_clk,
  input wire logic ref_int_en,
  input wire logic power_fail,
  // processor side
  input wire logic mem_clk,
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [BANK_ABITS:0] cpu_addr,
  output logic cpu_wait,
  // memory array side
  output logic [1:0] bank_ce,
  output logic [BANK_ABITS-1:0] mem_addr,
  output logic mem_rw,
  output logic mem_cs_b,
  // clock line drivers and power
  output logic mclk_drv_oe,
  output logic sclk_drv_oe,
  output logic bat,
  output logic bat_b,
  output logic aux_pwr_off,
  output logic hold
);
  initial
  begin
    if (ROW_BITS < 1 || ROW_BITS > BANK_ABITS || PRE_CYC < 1 || CE_CYC < 1 || DIST_CYC < 2)
      $error("pfrc_top: unsupported parameters");
  end

  pfrc_ref_e st;
  pfrc_ref_e next_st;
  logic ref_clk_d, mem_clk_d, next_ref_clk_d, next_mem_clk_d;
  logic [ROW_BITS-1:0] row, next_row;
  logic next_hold, next_bat;
  logic [$clog2(DIST_CYC+1)-1:0] tick, next_tick;
  logic cpu_busy, next_cpu_busy;
  logic [1:0] next_bank_ce;
  logic [BANK_ABITS-1:0] next_mem_addr;
  logic next_mem_rw, next_mem_cs_b;
  logic pre_trig, pre_act, pre_done, ce_act, ce_done;
  logic ref_edge, mem_edge, int_tick;
  logic acc_take;

  // timers for pretrigger and standby chip-enable pulse
  pfrc_pulse #(.LEN(PRE_CYC)) u_pre (
    .clk(clk), .rst_b(rst_b), .trig(pre_trig), .active(pre_act), .done(pre_done));
  pfrc_pulse #(.LEN(CE_CYC)) u_ce (
    .clk(clk), .rst_b(rst_b), .trig(pre_done), .active(ce_act), .done(ce_done));

  assign ref_edge = ref_clk && !ref_clk_d;
  assign mem_edge = mem_clk && !mem_clk_d;
  // internal oscillator covers the case of no external refresh clock
  assign int_tick = ref_int_en && (tick == '0);

  always_comb
  begin
    next_ref_clk_d = ref_clk;
    next_mem_clk_d = mem_clk;
    next_tick = (tick == '0) ? ($bits(tick))'(DIST_CYC - 1) : tick - 1'b1;
    next_st = st;
    next_row = row;
    next_hold = hold;
    pre_trig = 1'b0;
    case (st)
      PFRC_IDLE:
        // a refresh edge or tick that lands while a processor cycle is in flight is dropped, not held
        if ((ref_edge || int_tick) && !cpu_busy)
        begin
          pre_trig = 1'b1;
          next_st = PFRC_PRE;
          next_hold = 1'b1;
        end
      PFRC_PRE:
        if (pre_done)
          next_st = PFRC_CE;
      PFRC_CE:
        if (ce_done)
        begin
          next_st = PFRC_IDLE;
          next_hold = 1'b0;
          next_row = row + 1'b1;
        end
      default:
        next_st = PFRC_IDLE;
    endcase
  end

  // mode flop: J = power_fail, K = its complement, clocked by memory clock
  always_comb
  begin
    next_bat = bat;
    // an access taken on this very edge also blocks the change, so its cycle is never cut
    if (mem_edge && !hold && !cpu_busy && !acc_take)
      next_bat = power_fail;
  end

  always_comb
  begin
    // busy covers only the cycle in which the access outputs stand, so refresh can follow
    next_cpu_busy = 1'b0;
    next_bank_ce = 2'h0;
    next_mem_addr = mem_addr;
    next_mem_rw = 1'b1;
    next_mem_cs_b = 1'b1;
    if (st == PFRC_CE)
    begin
      next_bank_ce = 2'h3;
      next_mem_addr = '0;
      next_mem_addr[ROW_BITS-1:0] = row;
      next_mem_rw = 1'b0;
      next_mem_cs_b = 1'b1;
      next_cpu_busy = 1'b0;
    end
    else if (acc_take)
    begin
      next_cpu_busy = 1'b1;
      next_bank_ce[cpu_addr[BANK_ABITS]] = 1'b1;
      next_mem_addr = cpu_addr[BANK_ABITS-1:0];
      next_mem_rw = !cpu_wr;
      next_mem_cs_b = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st <= PFRC_IDLE;
      ref_clk_d <= 1'b0;
      mem_clk_d <= 1'b0;
      row <= '0;
      hold <= 1'b0;
      bat <= 1'b0;
      tick <= '0;
      cpu_busy <= 1'b0;
      bank_ce <= 2'h0;
      mem_addr <= '0;
      mem_rw <= 1'b1;
      mem_cs_b <= 1'b1;
    end
    else
    begin
      st <= next_st;
      ref_clk_d <= next_ref_clk_d;
      mem_clk_d <= next_mem_clk_d;
      row <= next_row;
      hold <= next_hold;
      bat <= next_bat;
      tick <= next_tick;
      cpu_busy <= next_cpu_busy;
      bank_ce <= next_bank_ce;
      mem_addr <= next_mem_addr;
      mem_rw <= next_mem_rw;
      mem_cs_b <= next_mem_cs_b;
    end
  end

  assign bat_b = !bat;
  assign sclk_drv_oe = bat;
  assign mclk_drv_oe = !bat;
  assign aux_pwr_off = bat;
  // access is released once refresh returns to idle and bat is low (not in standby)
  assign cpu_wait = cpu_req && (bat || st != PFRC_IDLE || pre_trig);
  assign acc_take = !bat && cpu_req && (st == PFRC_IDLE) && !pre_trig;

  sequence s_pre_end;
    (st == PFRC_PRE) && pre_done;
  endsequence

  sequence s_ce_run;
    (st == PFRC_CE) && ce_act && hold;
  endsequence

  a_hold_pre: assert property (@(posedge clk) disable iff (!rst_b) pre_act |-> hold)
    else $error("hold low during pretrigger");
  a_pre_len: assert property (@(posedge clk) disable iff (!rst_b)
    pre_trig |=> pre_act [*3])
    else $error("pretrigger too short");
  a_ce_follow: assert property (@(posedge clk) disable iff (!rst_b) pre_done |=> ce_act)
    else $error("chip-enable pulse did not follow pretrigger");
  a_pre_to_ce: assert property (@(posedge clk) disable iff (!rst_b) s_pre_end |=> s_ce_run)
    else $error("chip-enable phase did not follow pretrigger");
  a_hold_clear: assert property (@(posedge clk) disable iff (!rst_b) ce_done |=> !hold)
    else $error("hold not cleared after chip-enable");
  a_mode_stable: assert property (@(posedge clk) disable iff (!rst_b) hold |=> $stable(bat))
    else $error("mode changed while hold set");
  a_one_driver: assert property (@(posedge clk) disable iff (!rst_b) !(mclk_drv_oe && sclk_drv_oe))
    else $error("both clock drivers enabled");
  a_ref_write: assert property (@(posedge clk) disable iff (!rst_b)
    (st == PFRC_CE) |=> (!mem_rw && mem_cs_b))
    else $error("refresh cycle not a deselected write");
  a_one_bank: assert property (@(posedge clk) disable iff (!rst_b)
    (!mem_cs_b) |-> $onehot(bank_ce))
    else $error("access clocks both banks");
  a_wait_ref: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_req && st != PFRC_IDLE) |-> cpu_wait)
    else $error("access not held during refresh");
  a_row_step: assert property (@(posedge clk) disable iff (!rst_b)
    ce_done |=> row == $past(row) + 1'b1)
    else $error("refresh row not advanced");
  a_pwr_bat: assert property (@(posedge clk) disable iff (!rst_b) aux_pwr_off == bat)
    else $error("power control not tied to standby");
  a_bat_sync: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(bat) |-> $past(mem_edge) && bat == $past(power_fail))
    else $error("mode changed off memory clock edge");
endmodule

/* File: testbench/pfrc_cpu_model.sv */
// Purpose: processor bus model, memory clock and held access requests
// Assumes: a request stays up until wait is seen low at an edge
// Notes: idle address lines toggle so stale values never pass
`timescale 1ns/1ps
module pfrc_cpu_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench control
  input wire logic go,
  input wire logic [12:0] addr,
  input wire logic wr,
  output logic busy,
  // processor bus
  input wire logic cpu_wait,
  output logic mem_clk,
  output logic cpu_req,
  output logic cpu_wr,
  output logic [12:0] cpu_addr
);
  assign busy = cpu_req;
  always_ff @(posedge clk)
  begin
    mem_clk <= rst_b ? ~mem_clk : 1'b0;
    if (!rst_b)
    begin
      cpu_req <= 1'b0;
      cpu_wr <= 1'b0;
      cpu_addr <= 13'h0000;
    end
    else if (cpu_req)
    begin
      if (!cpu_wait)
        cpu_req <= 1'b0;
    end
    else if (go)
    begin
      cpu_req <= 1'b1;
      cpu_wr <= wr;
      cpu_addr <= addr;
    end
    else
      cpu_addr <= ~cpu_addr;
  end
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the refresh and power-fail controller
// Assumes: short pulse lengths set through parameters
// Notes: timing expectations derive from the localparams
`timescale 1ns/1ps
module tb;
  localparam int PRE = 4;
  localparam int CEN = 2;
  localparam int DIST = 20;
  logic clk = 0, rst_b = 0, ref_clk = 0, ref_int_en = 0, power_fail = 0, go = 0, wr = 0;
  logic [12:0] addr = 13'h0000;
  logic busy, mem_clk, cpu_req, cpu_wr, cpu_wait, mem_rw, mem_cs_b, mo, so, bat, bat_b, apo, hold;
  logic [12:0] cpu_addr;
  logic [1:0] bank_ce;
  logic [11:0] mem_addr;
  logic [4:0] row;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  pfrc_top #(.PRE_CYC(PRE), .CE_CYC(CEN), .DIST_CYC(DIST)) i_dut (.clk, .rst_b, .ref_clk, .ref_int_en,
    .power_fail, .mem_clk, .cpu_req, .cpu_wr, .cpu_addr, .cpu_wait, .bank_ce, .mem_addr, .mem_rw,
    .mem_cs_b, .mclk_drv_oe(mo), .sclk_drv_oe(so), .bat, .bat_b, .aux_pwr_off(apo), .hold);
  pfrc_cpu_model i_cpu (.clk, .rst_b, .go, .addr, .wr, .busy, .cpu_wait, .mem_clk, .cpu_req, .cpu_wr,
    .cpu_addr);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc1();
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // pf raises power fail inside the pretrigger; the mode must wait for hold to clear
  task automatic refresh(input logic pf, input logic rowck);
    logic b0;
    int n;
    @(posedge clk);
    ref_clk <= 1'b1;
    #1;
    repeat (9) if (hold !== 1'b1) cyc1();
    chk(16'(hold), 16'h1);
    b0 = bat;
    n = 0;
    while (bank_ce === 2'h0 && n < 99)
    begin
      @(posedge clk);
      if (pf) power_fail <= 1'b1;
      #1;
      n++;
    end
    // bank enables are registered, so they rise one cycle after the pretrigger ends
    chk(16'(n), 16'(PRE + 1));
    chk({bank_ce, mem_rw, mem_cs_b, bat}, {4'hD, b0});
    if (rowck) chk(16'(mem_addr[4:0]), 16'(row + 5'h01));
    row = mem_addr[4:0];
    n = 0;
    while (bank_ce === 2'h3 && n < 99)
    begin
      cyc1();
      n++;
    end
    chk(16'(n), 16'(CEN));
    @(posedge clk);
    ref_clk <= 1'b0;
    #1;
    chk(16'(hold), 16'h0);
  endtask
  task automatic access(input logic [12:0] a, input logic w, input logic during_ref);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    if (during_ref) chk(16'(cpu_wait), 16'h1);
    n = 0;
    while (busy !== 1'b0 && n < 99)
    begin
      cyc1();
      n++;
    end
    chk({bank_ce, mem_addr, mem_rw, mem_cs_b}, {a[12], ~a[12], a[11:0], ~w, 1'b0});
  endtask
  task automatic wait_bat(input logic b);
    int n;
    n = 0;
    while (bat !== b && n < 99)
    begin
      cyc1();
      n++;
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    int n;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    cyc1();
    chk({bank_ce, mem_rw, mem_cs_b, bat, hold, mo, so, apo}, 9'h064);
    refresh(1'b0, 1'b0);
    refresh(1'b0, 1'b1);
    access(13'h1ABC, 1'b1, 1'b0);
    access(13'h0123, 1'b0, 1'b0);
    fork
      refresh(1'b0, 1'b1);
      begin
        repeat (3) cyc1();
        access(13'h1F00, 1'b0, 1'b1);
      end
    join
    refresh(1'b1, 1'b1);
    wait_bat(1'b1);
    chk({bat, bat_b, mo, so, apo}, 5'h13);
    refresh(1'b0, 1'b1);
    // an access raised in standby must wait until the mode returns
    fork
      access(13'h0456, 1'b1, 1'b1);
      begin
        repeat (4) cyc1();
        @(posedge clk);
        power_fail <= 1'b0;
        wait_bat(1'b0);
      end
    join
    chk({bat, mo, so, apo}, 4'h4);
    @(posedge clk);
    ref_int_en <= 1'b1;
    #1;
    repeat (DIST + 3) if (hold !== 1'b1) cyc1();
    chk(16'(hold), 16'h1);
    n = 0;
    while (hold === 1'b1 && n < 99)
    begin
      cyc1();
      n++;
    end
    while (hold !== 1'b1 && n < 99)
    begin
      cyc1();
      n++;
    end
    chk(16'(n), 16'(DIST));
    @(posedge clk);
    ref_int_en <= 1'b0;
    repeat (40) cyc1();
    chk(16'(hold), 16'h0);
    tally_and_finish();
  end
endmodule
